// *** gfd_consts.svh ***
`ifndef GFD_CONSTS_SVH
`define GFD_CONSTS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define GFD_CTRL_ADDR 12'h000
`define GFD_DIV_ADDR 12'h004
`define GFD_CMD_ADDR 12'h008
`define GFD_STAT_ADDR 12'h00C

// ----------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------
`define GFD_CTRL_SRC_BIT 0
`define GFD_CTRL_EDGE_BIT 1
`define GFD_CTRL_TB_LSB 4
`define GFD_CTRL_TB_MSB 6
`define GFD_CTRL_GATE_LSB 8
`define GFD_CTRL_GATE_MSB 10
`define GFD_CTRL_OUT_LSB 12
`define GFD_CTRL_OUT_MSB 13
`define GFD_CMD_ARM_BIT 0
`define GFD_CMD_STOP_BIT 1

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define GFD_CTRL_RST 32'h0000_0000
`define GFD_DIV_RST 16'h0002
`define GFD_DIV_W 16

// ----------------------------------------------------------------------
// timebase frequencies in Hz and their tick periods at sys_clk
// ----------------------------------------------------------------------
`define GFD_SYS_CLK_HZ 10000000
`define GFD_TB_1M_HZ 1000000
`define GFD_TB_100K_HZ 100000
`define GFD_TB_10K_HZ 10000
`define GFD_TB_1K_HZ 1000
`define GFD_TB_100_HZ 100
`define GFD_TB_20M_HZ 20000000
`define GFD_TB_1M_DIV (`GFD_SYS_CLK_HZ / `GFD_TB_1M_HZ)
`define GFD_TB_100K_DIV (`GFD_SYS_CLK_HZ / `GFD_TB_100K_HZ)
`define GFD_TB_10K_DIV (`GFD_SYS_CLK_HZ / `GFD_TB_10K_HZ)
`define GFD_TB_1K_DIV (`GFD_SYS_CLK_HZ / `GFD_TB_1K_HZ)
`define GFD_TB_100_DIV (`GFD_SYS_CLK_HZ / `GFD_TB_100_HZ)
`define GFD_TB_CNT_W 17

`endif

// *** gfd_divider.sv ***
`timescale 1ns/1ps
`include "gfd_consts.svh"


module gfd_divider (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic source_in,
   input wire logic gate_in,
   output logic count_out
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   gfd_pkg::gfd_core_t core_reg;
   gfd_pkg::gfd_core_t core_next;
   gfd_pkg::gfd_regs_t regs_reg;
   gfd_pkg::gfd_regs_t regs_next;
   gfd_pkg::gfd_apb_req_t req;
   gfd_pkg::gfd_apb_rsp_t rsp;
   gfd_pkg::gfd_cfg_t cfg;
   logic tb_wave;
   logic src_sel;
   logic src_edge;
   logic gate_ok;
   logic arm_cmd;
   logic stop_cmd;
   logic wr_en;
   logic addr_hit;
   logic pulse_style;
   logic idle_lvl;
   logic [31:0] rd_mux;

   assign req = '{paddr: paddr, psel: psel, penable: penable,
                  pwrite: pwrite, pwdata: pwdata};
   assign cfg = regs_reg.cfg;

   // ----------------------------------------------------------------------
   // timebase
   // ----------------------------------------------------------------------
   gfd_timebase gfd_timebase_inst (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .sel(cfg.timebase_sel),
      .tb_wave(tb_wave)
   );

   // ----------------------------------------------------------------------
   // apb slave: zero wait states, unmapped reads zero with pslverr
   // ----------------------------------------------------------------------
   assign wr_en = req.psel && req.penable && req.pwrite;
   assign arm_cmd = wr_en && (req.paddr == `GFD_CMD_ADDR)
                    && req.pwdata[`GFD_CMD_ARM_BIT];
   assign stop_cmd = wr_en && (req.paddr == `GFD_CMD_ADDR)
                     && req.pwdata[`GFD_CMD_STOP_BIT];

   always_comb begin
      addr_hit = 1'b1;
      rd_mux = '0;
      case (req.paddr)
         `GFD_CTRL_ADDR: begin
            rd_mux[`GFD_CTRL_SRC_BIT] = cfg.count_source_setting;
            rd_mux[`GFD_CTRL_EDGE_BIT] = cfg.decrement_edge_select;
            rd_mux[`GFD_CTRL_TB_MSB:`GFD_CTRL_TB_LSB] = cfg.timebase_sel;
            rd_mux[`GFD_CTRL_GATE_MSB:`GFD_CTRL_GATE_LSB] =
               cfg.gating_setting;
            rd_mux[`GFD_CTRL_OUT_MSB:`GFD_CTRL_OUT_LSB] =
               cfg.terminal_output_style;
         end
         `GFD_DIV_ADDR: rd_mux[`GFD_DIV_W-1:0] = regs_reg.divide_ratio;
         `GFD_CMD_ADDR: rd_mux = '0;
         `GFD_STAT_ADDR: rd_mux = {12'h000, core_reg.count,
                                   core_reg.tc_seen, count_out,
                                   core_reg.state};
         default: addr_hit = 1'b0;
      endcase
   end

   always_comb begin
      regs_next = regs_reg;
      if (req.psel && !req.penable && !req.pwrite) begin
         regs_next.prdata = rd_mux;
      end
      if (wr_en && req.paddr == `GFD_CTRL_ADDR) begin
         regs_next.cfg.count_source_setting =
            req.pwdata[`GFD_CTRL_SRC_BIT];
         regs_next.cfg.decrement_edge_select =
            req.pwdata[`GFD_CTRL_EDGE_BIT];
         // unknown timebase codes fall back to the slowest legal choice, unknown gate codes to free running
         if (req.pwdata[`GFD_CTRL_TB_MSB:`GFD_CTRL_TB_LSB] <= 3'h5) begin
            regs_next.cfg.timebase_sel = gfd_pkg::gfd_tb_t'(
               req.pwdata[`GFD_CTRL_TB_MSB:`GFD_CTRL_TB_LSB]);
         end else begin
            regs_next.cfg.timebase_sel = gfd_pkg::GFD_TB_100;
         end
         if (req.pwdata[`GFD_CTRL_GATE_MSB:`GFD_CTRL_GATE_LSB] <= 3'h4) begin
            regs_next.cfg.gating_setting = gfd_pkg::gfd_gate_t'(
               req.pwdata[`GFD_CTRL_GATE_MSB:`GFD_CTRL_GATE_LSB]);
         end else begin
            regs_next.cfg.gating_setting = gfd_pkg::GFD_GATE_FREE;
         end
         regs_next.cfg.terminal_output_style = gfd_pkg::gfd_out_t'(
            req.pwdata[`GFD_CTRL_OUT_MSB:`GFD_CTRL_OUT_LSB]);
      end
      if (wr_en && req.paddr == `GFD_DIV_ADDR) begin
         // a ratio of zero cannot divide; treat it as one
         if (req.pwdata[`GFD_DIV_W-1:0] == '0) begin
            regs_next.divide_ratio = `GFD_DIV_W'(1);
         end else begin
            regs_next.divide_ratio = req.pwdata[`GFD_DIV_W-1:0];
         end
      end
   end

   assign rsp.prdata = regs_reg.prdata;
   assign rsp.pready = 1'b1;
   assign rsp.pslverr = req.psel && req.penable && !addr_hit;
   assign prdata = rsp.prdata;
   assign pready = rsp.pready;
   assign pslverr = rsp.pslverr;

   // ----------------------------------------------------------------------
   // counting core
   // ----------------------------------------------------------------------
   assign src_sel = cfg.count_source_setting ? tb_wave : source_in;
   assign pulse_style =
      (cfg.terminal_output_style == gfd_pkg::GFD_OUT_HIGH_PULSE) ||
      (cfg.terminal_output_style == gfd_pkg::GFD_OUT_LOW_PULSE);
   // low styles idle high so the active phase is low
   assign idle_lvl =
      (cfg.terminal_output_style == gfd_pkg::GFD_OUT_LOW_PULSE) ||
      (cfg.terminal_output_style == gfd_pkg::GFD_OUT_LOW_TOGGLE);

   always_comb begin
      if (cfg.decrement_edge_select) begin
         src_edge = core_reg.src_d && !src_sel;
      end else begin
         src_edge = !core_reg.src_d && src_sel;
      end
      case (cfg.gating_setting)
         gfd_pkg::GFD_GATE_HIGH: gate_ok = gate_in;
         gfd_pkg::GFD_GATE_LOW: gate_ok = !gate_in;
         default: gate_ok = 1'b1;
      endcase
   end

   always_comb begin
      core_next = core_reg;
      core_next.src_d = src_sel;
      core_next.gate_d = gate_in;
      case (core_reg.state)
         gfd_pkg::GFD_ST_IDLE: begin
            core_next.out_lvl = 1'b0;
            if (arm_cmd) begin
               core_next.count = regs_reg.divide_ratio;
               core_next.tc_seen = 1'b0;
               if (cfg.gating_setting == gfd_pkg::GFD_GATE_RISE ||
                   cfg.gating_setting == gfd_pkg::GFD_GATE_FALL) begin
                  core_next.state = gfd_pkg::GFD_ST_WAIT_GATE;
               end else begin
                  core_next.state = gfd_pkg::GFD_ST_COUNT;
               end
            end
         end
         gfd_pkg::GFD_ST_WAIT_GATE: begin
            if ((cfg.gating_setting == gfd_pkg::GFD_GATE_RISE &&
                 !core_reg.gate_d && gate_in) ||
                (cfg.gating_setting == gfd_pkg::GFD_GATE_FALL &&
                 core_reg.gate_d && !gate_in)) begin
               core_next.state = gfd_pkg::GFD_ST_COUNT;
            end
         end
         gfd_pkg::GFD_ST_COUNT: begin
            if (src_edge) begin
               // pulse lasts one source period, or stays active while the ratio is one
               if (pulse_style) begin
                  core_next.out_lvl = 1'b0;
               end
               if (gate_ok) begin
                  if (core_reg.count <= `GFD_DIV_W'(1)) begin
                     core_next.count = regs_reg.divide_ratio;
                     core_next.tc_seen = 1'b1;
                     if (pulse_style) begin
                        core_next.out_lvl = 1'b1;
                     end else begin
                        core_next.out_lvl = ~core_reg.out_lvl;
                     end
                  end else begin
                     core_next.count = core_reg.count - `GFD_DIV_W'(1);
                  end
               end
            end
         end
         default: core_next.state = gfd_pkg::GFD_ST_IDLE;
      endcase
      if (stop_cmd) begin
         core_next.state = gfd_pkg::GFD_ST_IDLE;
         core_next.out_lvl = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         core_reg <= '0;
         regs_reg <= '{cfg: gfd_pkg::gfd_cfg_t'(0),
                       divide_ratio: `GFD_DIV_RST, prdata: 32'h0000_0000};
      end else begin
         core_reg <= core_next;
         regs_reg <= regs_next;
      end
   end

   assign count_out = core_reg.out_lvl ^ idle_lvl;

endmodule // gfd_divider

// *** gfd_divider_asserts.sv ***
`timescale 1ns/1ps
`include "gfd_consts.svh"

module gfd_divider_chk (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic source_in,
   input wire logic gate_in,
   input wire logic count_out
);
   logic src_q, tb_mode, quiet, wr;
   logic [2:0] since;
   logic [15:0] div_sh;
   assign wr = psel && penable && pwrite;
   // ----
   // shadows of software settings; the core stays opaque
   // ----
   always_ff @(posedge sys_clk) begin
      src_q <= source_in;
      if (sys_rst) begin
         tb_mode <= 1'b0;
         quiet <= 1'b1;
         since <= 3'h0;
         div_sh <= `GFD_DIV_RST;
      end else begin
         if (wr && paddr == `GFD_CTRL_ADDR) tb_mode <= pwdata[0];
         if (wr && paddr == `GFD_DIV_ADDR)
            div_sh <= (pwdata[15:0] == 16'h0) ? 16'h1 : pwdata[15:0];
         if (wr && paddr == `GFD_CMD_ADDR && pwdata[1:0] != 2'h0)
            quiet <= pwdata[1];
         // a bus write or a source_in edge restarts the age count; timebase edges do not
         if (wr || source_in != src_q) since <= 3'h0;
         else if (since != 3'h7) since <= since + 3'h1;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_bad_addr;
      s_access ##0 (paddr > `GFD_STAT_ADDR);
   endsequence
   a_ready_const: assert property (pready) else $error("pready low");
   a_err_unmapped: assert property (s_bad_addr |-> pslverr)
      else $error("no error on unmapped access");
   a_err_mapped: assert property (
      s_access ##0 (paddr <= `GFD_STAT_ADDR) |-> !pslverr)
      else $error("error on mapped access");
   a_err_idle: assert property (!(psel && penable) |-> !pslverr)
      else $error("error outside access");
   a_rd_unmapped: assert property (s_bad_addr ##0 !pwrite |-> prdata == 0)
      else $error("unmapped read not zero");
   a_div_readback: assert property (s_access ##0
      (!pwrite && paddr == `GFD_DIV_ADDR) |-> prdata[15:0] == div_sh)
      else $error("divisor readback wrong");
   a_quiet_hold: assert property (
      quiet && !$past(wr) |-> $stable(count_out))
      else $error("output moved while idle");
   a_out_cause: assert property (
      !tb_mode && $changed(count_out) |-> since < 3'h5)
      else $error("output moved without source edge");
endmodule // gfd_divider_chk

bind gfd_divider gfd_divider_chk gfd_divider_chk_inst (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .source_in(source_in),
   .gate_in(gate_in), .count_out(count_out)
);

// *** gfd_pkg.sv ***
package gfd_pkg;

   // timebase selection codes; 20 MHz exceeds sys_clk and is clamped
   typedef enum logic [2:0] {
      GFD_TB_1M,
      GFD_TB_100K,
      GFD_TB_10K,
      GFD_TB_1K,
      GFD_TB_100,
      GFD_TB_20M
   } gfd_tb_t;

   typedef enum logic [2:0] {
      GFD_GATE_FREE,
      GFD_GATE_HIGH,
      GFD_GATE_LOW,
      GFD_GATE_RISE,
      GFD_GATE_FALL
   } gfd_gate_t;

   typedef enum logic [1:0] {
      GFD_OUT_HIGH_PULSE,
      GFD_OUT_LOW_PULSE,
      GFD_OUT_HIGH_TOGGLE,
      GFD_OUT_LOW_TOGGLE
   } gfd_out_t;

   typedef enum logic [1:0] {
      GFD_ST_IDLE,
      GFD_ST_WAIT_GATE,
      GFD_ST_COUNT
   } gfd_state_t;

   typedef struct packed {
      logic count_source_setting;
      logic decrement_edge_select;
      gfd_tb_t timebase_sel;
      gfd_gate_t gating_setting;
      gfd_out_t terminal_output_style;
   } gfd_cfg_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } gfd_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } gfd_apb_rsp_t;

   typedef struct packed {
      gfd_state_t state;
      logic [15:0] count;
      logic src_d;
      logic gate_d;
      logic out_lvl;
      logic tc_seen;
   } gfd_core_t;

   typedef struct packed {
      gfd_cfg_t cfg;
      logic [15:0] divide_ratio;
      logic [31:0] prdata;
   } gfd_regs_t;

endpackage

// *** gfd_src_model.sv ***
`timescale 1ns/1ps

// ----
// external source square wave and gate pin
// ----
module gfd_src_model (
   input wire logic sys_clk,
   input wire logic [15:0] half,
   input wire logic gate_lvl,
   output logic source_in,
   output logic gate_in
);
   logic [15:0] cnt = 16'h0;
   initial source_in = 1'b0;
   initial gate_in = 1'b0;
   // half may change mid-phase; the compare tolerates an overshoot
   always @(posedge sys_clk) begin
      gate_in <= gate_lvl;
      if (cnt + 16'h1 >= half) begin
         cnt <= 16'h0;
         source_in <= ~source_in;
      end else cnt <= cnt + 16'h1;
   end
endmodule // gfd_src_model

// *** gfd_timebase.sv ***
`timescale 1ns/1ps
`include "gfd_consts.svh"

// ----------------------------------------------------------------------
// internal timebase: square wave at the selected frequency, with 20 MHz clamped to sys_clk/2
// ----------------------------------------------------------------------
module gfd_timebase (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire gfd_pkg::gfd_tb_t sel,
   output logic tb_wave
);

   typedef struct packed {
      logic [`GFD_TB_CNT_W-1:0] cnt;
      logic wave;
   } gfd_tb_state_t;

   gfd_tb_state_t st_reg;
   gfd_tb_state_t st_next;
   logic [`GFD_TB_CNT_W-1:0] half;

   always_comb begin
      case (sel)
         gfd_pkg::GFD_TB_1M: half = `GFD_TB_CNT_W'(`GFD_TB_1M_DIV / 2);
         gfd_pkg::GFD_TB_100K: half = `GFD_TB_CNT_W'(`GFD_TB_100K_DIV / 2);
         gfd_pkg::GFD_TB_10K: half = `GFD_TB_CNT_W'(`GFD_TB_10K_DIV / 2);
         gfd_pkg::GFD_TB_1K: half = `GFD_TB_CNT_W'(`GFD_TB_1K_DIV / 2);
         gfd_pkg::GFD_TB_100: half = `GFD_TB_CNT_W'(`GFD_TB_100_DIV / 2);
         // fastest rate we can make is sys_clk/2; 20 MHz is clamped there
         default: half = `GFD_TB_CNT_W'(1);
      endcase
   end

   always_comb begin
      st_next = st_reg;
      if (st_reg.cnt >= half - `GFD_TB_CNT_W'(1)) begin
         st_next.cnt = '0;
         st_next.wave = ~st_reg.wave;
      end else begin
         st_next.cnt = st_reg.cnt + `GFD_TB_CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tb_wave = st_reg.wave;

endmodule // gfd_timebase

// *** tb_gated_frequency_divider.sv ***
`timescale 1ns/1ps
`include "gfd_consts.svh"

module tb_gated_frequency_divider;
   logic sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, gate_lvl = 1'b0, act = 1'b1, prev = 1'b0, pl;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, source_in, gate_in, count_out;
   logic [15:0] half = 16'h8, lfsr = 16'h1EB4, n, h;
   logic [63:0] e;
   logic [63:0] exq[$];
   int err_count = 0, n_compared = 0, cyc = 0, rise, tog, wid, wbeg, p;

   gfd_divider gfd_divider_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .source_in(source_in), .gate_in(gate_in), .count_out(count_out));
   gfd_src_model gfd_src_model_inst (.sys_clk(sys_clk), .half(half),
      .gate_lvl(gate_lvl), .source_in(source_in), .gate_in(gate_in));

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   function automatic logic [31:0] cfg(input int o, g, t, d, s);
      return (o << 12) | (g << 8) | (t << 4) | (d << 1) | s;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("compares=%0d mismatches=%0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----
   // bus cycles; one idle edge after each so strobes never double up
   // ----
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] v, m);
      exq.push_back({m, v});
      apb(1'b0, a, 32'h0);
   endtask

   // stop first so the new style's idle level can be seen
   task automatic arm(input logic [31:0] c, input logic [15:0] dv);
      act = ~c[12];
      apb(1'b1, `GFD_CMD_ADDR, 32'h2);
      apb(1'b1, `GFD_CTRL_ADDR, c);
      apb(1'b1, `GFD_DIV_ADDR, {16'h0, dv});
      chk(count_out, c[12]);
      apb(1'b1, `GFD_CMD_ADDR, 32'h1);
   endtask

   // settle for len cycles, then count events over len more
   task automatic win(input int len, input int exp, input logic tgl);
      repeat (len) @(posedge sys_clk);
      @(negedge sys_clk);
      rise = 0;
      tog = 0;
      repeat (len) @(posedge sys_clk);
      // let the monitor finish the last edge before reading its counts
      @(negedge sys_clk);
      chk(tgl ? tog : rise, exp);
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (psel && penable && pready && !pwrite && exq.size() > 0) begin
         e = exq.pop_front();
         chk(prdata & e[63:32], e[31:0]);
      end
      if (psel && penable) begin
         chk(pslverr, paddr > `GFD_STAT_ADDR);
      end
      if (count_out !== prev) begin
         tog++;
         if (count_out === act) begin
            rise++;
            wbeg = cyc;
            pl = source_in;
         end else wid = cyc - wbeg;
      end
      prev = count_out;
      if (cyc == 50000) begin
         err_count++;
         conclude();
      end
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rd(`GFD_CTRL_ADDR, 32'h0, 32'hFFFFFFFF);
      rd(`GFD_DIV_ADDR, 32'h2, 32'hFFFF);
      rd(`GFD_STAT_ADDR, 32'h0, 32'h7);
      apb(1'b1, 12'h010, 32'hFFFFFFFF);
      rd(12'h010, 32'h0, 32'hFFFFFFFF);
      apb(1'b1, `GFD_DIV_ADDR, 32'h0);
      rd(`GFD_DIV_ADDR, 32'h1, 32'hFFFF);
      apb(1'b1, `GFD_CTRL_ADDR, 32'h0560);
      rd(`GFD_CTRL_ADDR, 32'h0040, 32'h0770);
      for (int s = 0; s < 4; s++) begin
         for (int d = 0; d < 2; d++) begin
            n = 16'h2 + rnd() % 16'h4;
            gate_lvl <= lfsr[3];
            arm(cfg(s, 0, 0, d, 0), n);
            win(3 * n * 16, 3, s > 1);
            if (s < 2) begin
               chk(wid, 16);
               chk(pl, d == 0);
            end
         end
      end
      for (int g = 1; g < 5; g++) begin
         h = 16'h3 + rnd() % 16'h6;
         n = 16'h2 + rnd() % 16'h4;
         half <= h;
         gate_lvl <= (g == 2 || g == 4);
         arm(cfg(0, g, 0, 0, 0), n);
         win(6 * n * h, 0, 1'b0);
         gate_lvl <= !(g == 2 || g == 4);
         win(6 * n * h, 3, 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         p = (i == 3) ? 2 : 10 ** (i + 1);
         arm(cfg(0, 0, (i == 3) ? 5 : i, 0, 1), 16'h2);
         win(6 * p, 3, 1'b0);
         chk(wid, p);
         rd(`GFD_STAT_ADDR, 32'hA, 32'hB);
      end
      apb(1'b1, `GFD_CMD_ADDR, 32'h2);
      repeat (4) @(posedge sys_clk);
      chk(count_out, 1'b0);
      rd(`GFD_STAT_ADDR, 32'h8, 32'hB);
      conclude();
   end
endmodule // tb_gated_frequency_divider
